/* File: hw/aec_params.svh */
/*
  Constants of the event counter block: register indices, field positions,
  reset values and bus widths.
  Assumes inclusion by name from the package and the counter module.

// Function
// RL1: Chained halves count 65536 events before wrapping to zero.
// RL2: Counting follows event pin edges, not the processor's main or sub clocks.
// RL3: Split select 0: lower counts low pin, upper counts lower wraps.
// RL4: Split select 1: upper counts high pin, lower counts low pin, independently.
// RL5: Reset clears control/status to zero: chained, disabled, counters held.
// RL6: Upper overflow flag sets when upper counter wraps from all ones.
// RL7: Lower overflow flag sets on lower wrap only in split mode.
// RL8: Flag cleared by reading it as one then writing zero.
// RL9: Writing one to a flag leaves it unchanged.
// RL10: Bit 5 is plain read/write storage resetting to zero.
// RL11: Upper count enable gates upper event input; zero holds value.
// RL12: Lower count enable gates lower event input; zero holds value.
// RL13: Upper release bit zero holds upper counter cleared.
// RL14: Lower release bit zero holds lower counter cleared.
// RL15: Count registers are 8-bit, read-only, reset zero, cleared by release.
// RL16: Overflow raises an interrupt request without polling.
// RL17: Software can put the module into standby independently.
// RL18: Gating bit 3 zero means standby; one, the reset value, operates.
// RL19: Overflow sets interrupt request; forwarding gated by enable outside.
// RL20: In low power, counters still count but flags do not update.
// RL21: Event pins are synchronised before driving counters or flags.
*/
`ifndef AEC_PARAMS_SVH
`define AEC_PARAMS_SVH

`define AEC_ADDR_W        18
`define AEC_IDX_W         16
`define AEC_DATA_W        32
`define AEC_REG_W         8

`define AEC_IDX_CTRL      16'hff95
`define AEC_IDX_UPPER     16'hff96
`define AEC_IDX_LOWER     16'hff97
`define AEC_IDX_GATING    16'hfffb

`define AEC_CTRL_RESET    8'h00
`define AEC_COUNT_RESET   8'h00
`define AEC_GATING_RESET  8'hff
`define AEC_GATING_FIXED  8'hf0
`define AEC_COUNT_MAX     8'hff
`define AEC_COUNT_ONE     8'h01

`define AEC_BIT_UPPER_OVF 7
`define AEC_BIT_LOWER_OVF 6
`define AEC_BIT_GATE_ON   3

`endif

/* File: hw/aec_pkg.sv */
/*
  Types of the event counter block.
  Assumes the constants header is on the include path.
*/
`include "aec_params.svh"

package aec_pkg;

  typedef struct packed {
    logic spare;
    logic split;
    logic upper_en;
    logic lower_en;
    logic upper_rel;
    logic lower_rel;
  } aec_ctrl_s;

  typedef enum logic [2:0] {
    AEC_REG_CTRL,
    AEC_REG_UPPER,
    AEC_REG_LOWER,
    AEC_REG_GATING,
    AEC_REG_NONE
  } aec_reg_e;

  typedef logic [`AEC_REG_W-1:0] aec_byte_t;

endpackage : aec_pkg

/* File: hw/aec_counter.sv */
/*
  Event counter with APB register slave: two 8-bit counters, chained or split,
  overflow flags, standby gating and an overflow request pulse.
  Assumes event pins are asynchronous and slower than a quarter of REF_CLK_I;
  the interrupt controller outside holds request and enable bits.
*/
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "aec_params.svh"

module aec_counter (
  input  wire logic                    REF_CLK_I,
  input  wire logic                    RESET_I,
  input  wire logic                    PSEL_I,
  input  wire logic                    PENABLE_I,
  input  wire logic                    PWRITE_I,
  input  wire logic [`AEC_ADDR_W-1:0]  PADDR_I,
  input  wire logic [`AEC_DATA_W-1:0]  PWDATA_I,
  output logic      [`AEC_DATA_W-1:0]  PRDATA_O,
  output logic                         PREADY_O,
  output logic                         PSLVERR_O,
  input  wire logic                    EVENT_INPUT_HIGH_I,
  input  wire logic                    EVENT_INPUT_LOW_I,
  input  wire logic                    LOW_POWER_I,
  output logic                         EVENT_IRQ_REQUEST_O
);

  function automatic aec_pkg::aec_reg_e decode(input logic [`AEC_ADDR_W-1:0] addr);
    aec_pkg::aec_reg_e sel;
    sel = aec_pkg::AEC_REG_NONE;
    if (addr[1:0] == 2'h0) begin
      if (addr[`AEC_ADDR_W-1:2] == `AEC_IDX_CTRL) sel = aec_pkg::AEC_REG_CTRL;
      if (addr[`AEC_ADDR_W-1:2] == `AEC_IDX_UPPER) sel = aec_pkg::AEC_REG_UPPER;
      if (addr[`AEC_ADDR_W-1:2] == `AEC_IDX_LOWER) sel = aec_pkg::AEC_REG_LOWER;
      if (addr[`AEC_ADDR_W-1:2] == `AEC_IDX_GATING) sel = aec_pkg::AEC_REG_GATING;
    end
    return sel;
  endfunction : decode

  function automatic aec_pkg::aec_byte_t bump(input aec_pkg::aec_byte_t value);
    return aec_pkg::aec_byte_t'(value + `AEC_COUNT_ONE);
  endfunction : bump

  aec_pkg::aec_ctrl_s  ctrl;
  logic                upper_ovf;
  logic                lower_ovf;
  logic                upper_armed;
  logic                lower_armed;
  aec_pkg::aec_byte_t  gating;
  aec_pkg::aec_byte_t  upper_count;
  aec_pkg::aec_byte_t  lower_count;
  logic [1:0]          high_sync;
  logic [1:0]          low_sync;
  logic                high_prev;
  logic                low_prev;
  aec_pkg::aec_reg_e   sel;
  aec_pkg::aec_byte_t  read_byte;
  logic                done;
  logic                wr_done;
  logic                rd_done;
  logic                active;
  logic                flags_live;
  logic                high_edge;
  logic                low_edge;
  logic                lower_step;
  logic                lower_wrap;
  logic                upper_src;
  logic                upper_step;
  logic                upper_wrap;
  logic                set_upper;
  logic                set_lower;
  logic                ctrl_wr;

  assign sel        = decode(PADDR_I);
  assign done       = PSEL_I & PENABLE_I & PREADY_O;
  assign wr_done    = done & PWRITE_I;
  assign rd_done    = done & ~PWRITE_I;
  assign active     = gating[`AEC_BIT_GATE_ON];                         // RL17 RL18
  assign flags_live = active & ~LOW_POWER_I;                            // RL20
  assign ctrl_wr    = wr_done & (sel == aec_pkg::AEC_REG_CTRL) & active;

  // Two sync flops and a previous-value flop per pin; edge logic reads the last two
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      high_sync <= 2'h0;
      low_sync  <= 2'h0;
      high_prev <= 1'b0;
      low_prev  <= 1'b0;
    end else begin
      high_sync <= {high_sync[0], EVENT_INPUT_HIGH_I};                 // RL21
      low_sync  <= {low_sync[0], EVENT_INPUT_LOW_I};                   // RL21
      high_prev <= high_sync[1];
      low_prev  <= low_sync[1];
    end
  end

  // Rising pin edges; a free sampling clock stands in for the pin clocking
  assign high_edge  = high_sync[1] & ~high_prev;                        // RL2
  assign low_edge   = low_sync[1] & ~low_prev;                          // RL2
  assign lower_step = active & ctrl.lower_en & ctrl.lower_rel & low_edge;   // RL12
  assign lower_wrap = lower_step & (lower_count == `AEC_COUNT_MAX);
  assign upper_src  = ctrl.split ? high_edge : lower_wrap;              // RL3 RL4
  assign upper_step = active & ctrl.upper_en & ctrl.upper_rel & upper_src;  // RL11
  assign upper_wrap = upper_step & (upper_count == `AEC_COUNT_MAX);     // RL1
  assign set_upper  = upper_wrap & flags_live;                          // RL6
  assign set_lower  = lower_wrap & ctrl.split & flags_live;             // RL7

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      lower_count <= `AEC_COUNT_RESET;                                  // RL15
    end else if (!ctrl.lower_rel) begin
      lower_count <= `AEC_COUNT_RESET;                                  // RL14
    end else if (lower_step) begin
      lower_count <= bump(lower_count);
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      upper_count <= `AEC_COUNT_RESET;                                  // RL15
    end else if (!ctrl.upper_rel) begin
      upper_count <= `AEC_COUNT_RESET;                                  // RL13
    end else if (upper_step) begin
      upper_count <= bump(upper_count);
    end
  end

  // Control bits; held in standby
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      ctrl <= aec_pkg::aec_ctrl_s'(6'(`AEC_CTRL_RESET));                // RL5
    end else if (ctrl_wr) begin
      ctrl <= aec_pkg::aec_ctrl_s'(PWDATA_I[5:0]);                      // RL10
    end
  end

  // A read that sees the flag at one arms the next zero write
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      upper_armed <= 1'b0;
      lower_armed <= 1'b0;
    end else if (done && sel == aec_pkg::AEC_REG_CTRL) begin
      upper_armed <= rd_done & upper_ovf;                               // RL8
      lower_armed <= rd_done & lower_ovf;                               // RL8
    end
  end

  // Set beats clear so an overflow in the clearing cycle is kept
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      upper_ovf <= 1'b0;
      lower_ovf <= 1'b0;
    end else begin
      if (set_upper) begin
        upper_ovf <= 1'b1;
      end else if (ctrl_wr && upper_armed && !PWDATA_I[`AEC_BIT_UPPER_OVF]) begin
        upper_ovf <= 1'b0;                                              // RL8 RL9
      end
      if (set_lower) begin
        lower_ovf <= 1'b1;
      end else if (ctrl_wr && lower_armed && !PWDATA_I[`AEC_BIT_LOWER_OVF]) begin
        lower_ovf <= 1'b0;                                              // RL8 RL9
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      EVENT_IRQ_REQUEST_O <= 1'b0;
    end else begin
      EVENT_IRQ_REQUEST_O <= set_upper | set_lower;                     // RL16 RL19
    end
  end

  // Upper nibble has no storage and reads as ones
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      gating <= `AEC_GATING_RESET;                                      // RL18
    end else if (wr_done && sel == aec_pkg::AEC_REG_GATING) begin
      gating <= PWDATA_I[`AEC_REG_W-1:0] | `AEC_GATING_FIXED;           // RL17
    end
  end

  always_comb begin
    read_byte = `AEC_COUNT_RESET;
    unique case (sel)
      aec_pkg::AEC_REG_CTRL:   read_byte = {upper_ovf, lower_ovf, ctrl};
      aec_pkg::AEC_REG_UPPER:  read_byte = upper_count;                 // RL15
      aec_pkg::AEC_REG_LOWER:  read_byte = lower_count;                 // RL15
      aec_pkg::AEC_REG_GATING: read_byte = gating;
      aec_pkg::AEC_REG_NONE:   read_byte = `AEC_COUNT_RESET;
    endcase
  end

  // One wait state keeps read data and ready straight from flops
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= '0;
    end else if (PSEL_I && PENABLE_I && !PREADY_O) begin
      PREADY_O  <= 1'b1;
      PSLVERR_O <= (sel == aec_pkg::AEC_REG_NONE);
      PRDATA_O  <= {{(`AEC_DATA_W-`AEC_REG_W){1'b0}}, read_byte};
    end else begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end

endmodule : aec_counter

/* File: dv/aec_counter_assertions.sv */
/* Port checker for the event counter: bus timing, reset and low-power quiet.
   Assumes a bind onto aec_counter from the bench top. */
`timescale 1ns/1ps
`include "aec_params.svh"
module aec_counter_assertions (
  input wire logic                   REF_CLK_I,
  input wire logic                   RESET_I,
  input wire logic                   PSEL_I,
  input wire logic                   PENABLE_I,
  input wire logic [`AEC_ADDR_W-1:0] PADDR_I,
  input wire logic [`AEC_DATA_W-1:0] PRDATA_O,
  input wire logic                   PREADY_O,
  input wire logic                   PSLVERR_O,
  input wire logic                   LOW_POWER_I,
  input wire logic                   EVENT_IRQ_REQUEST_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  // Index decode only; the bench never issues unaligned addresses
  logic mapped;
  assign mapped = PADDR_I[17:2] inside {`AEC_IDX_CTRL, `AEC_IDX_UPPER, `AEC_IDX_LOWER, `AEC_IDX_GATING};
  sequence s_setup; PSEL_I && !PENABLE_I; endsequence
  sequence s_access; PSEL_I && PENABLE_I; endsequence
  property p_ready_late; s_setup ##1 s_access |=> PREADY_O; endproperty
  property p_ready_once; PREADY_O |=> !PREADY_O; endproperty
  property p_ready_access; PREADY_O |-> s_access; endproperty
  property p_err_map; PREADY_O |-> (PSLVERR_O == !mapped); endproperty
  property p_rdata_hold; !(PSEL_I && PENABLE_I) |=> $stable(PRDATA_O); endproperty
  property p_rdata_pad; PREADY_O |-> PRDATA_O[31:8] == 24'h0; endproperty
  property p_reset_quiet; $fell(RESET_I) |-> (!EVENT_IRQ_REQUEST_O && PRDATA_O == 32'h0)[*3]; endproperty
  property p_lp_quiet; LOW_POWER_I && $past(LOW_POWER_I) |-> !EVENT_IRQ_REQUEST_O; endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready late");
  a_ready_once: assert property (p_ready_once) else $error("ready too long");
  a_ready_access: assert property (p_ready_access) else $error("ready outside access");
  a_err_map: assert property (p_err_map) else $error("error flag wrong");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_rdata_pad: assert property (p_rdata_pad) else $error("read data upper bits set");
  a_reset_quiet: assert property (p_reset_quiet) else $error("not quiet after reset");
  a_lp_quiet: assert property (p_lp_quiet) else $error("request in low power");
endmodule : aec_counter_assertions

/* File: dv/aec_event_source.sv */
/* Event pin source: bursts of pulses on the two asynchronous event pins.
   Assumes the caller picks a width of at least two system clock periods. */
`timescale 1ns/1ps
module aec_event_source (
  output logic ev_hi_o,
  output logic ev_lo_o
);
  initial begin
    {ev_hi_o, ev_lo_o} = 2'b00;
  end
  // Edges land off the system clock, so sync delay varies per pulse
  task automatic burst(input logic hi, input int n, input int w);
    repeat (n) begin
      {ev_hi_o, ev_lo_o} = hi ? 2'b10 : 2'b01;
      #w;
      {ev_hi_o, ev_lo_o} = 2'b00;
      #w;
    end
  endtask : burst
endmodule : aec_event_source

/* File: dv/async_event_counter_test.sv */
/* Self-checking bench for aec_counter: APB master, event bursts, model of counts.
   Assumes the checker and the event source compile first. */
`timescale 1ns/1ps
`include "aec_params.svh"
module async_event_counter_test;
  logic        ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, low_power = 0;
  logic [17:0] paddr   = '0;
  logic [31:0] pwdata  = '0, prdata, r;
  logic        pready, pslverr, ev_hi, ev_lo, irq, e;
  int          n_fail  = 0, checked = 0, n_irq = 0, seed = 32'h9c58, i;
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (irq === 1'b1) n_irq <= n_irq + 1;
  aec_counter i_aec_counter (.REF_CLK_I(ref_clk), .RESET_I(reset), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .EVENT_INPUT_HIGH_I(ev_hi), .EVENT_INPUT_LOW_I(ev_lo), .LOW_POWER_I(low_power),
    .EVENT_IRQ_REQUEST_O(irq));
  aec_event_source i_aec_event_source (.ev_hi_o(ev_hi), .ev_lo_o(ev_lo));
  task give_verdict;
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [15:0] idx, input logic [7:0] d);
    int k;
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, idx, 2'b00, 24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge ref_clk);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    if (k == 20) begin n_fail++; give_verdict; end
  endtask : apb
  task rd_chk(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(r, {24'h0, exp});
  endtask : rd_chk
  // Counts start from zero; at most one wrap per counter in a run
  function automatic logic [25:0] expect_of(input logic [5:0] c, input int nh, input int nl, input logic lp);
    int wl, wh, nu;
    logic [7:0] lo, hi, f;
    wl = (c[2] & c[0]) ? nl / 256 : 0;
    lo = (c[2] & c[0]) ? nl[7:0] : 8'h00;
    nu = c[4] ? nh : wl;
    wh = (c[3] & c[1]) ? nu / 256 : 0;
    hi = (c[3] & c[1]) ? nu[7:0] : 8'h00;
    f = {wh > 0 && !lp, wl > 0 && c[4] && !lp, c};
    return {({1'b0, f[7]} + {1'b0, f[6]}), f, hi, lo};
  endfunction : expect_of
  task run(input logic [5:0] c, input int nh, input int nl, input logic lp);
    logic [25:0] x;
    x = expect_of(c, nh, nl, lp);
    apb(1'b0, `AEC_IDX_CTRL, 8'h00);
    apb(1'b1, `AEC_IDX_CTRL, 8'h00);
    apb(1'b1, `AEC_IDX_CTRL, {2'b00, c});
    low_power <= lp;
    n_irq = 0;
    i_aec_event_source.burst(1'b1, nh, 17 + {$random(seed)} % 24);
    i_aec_event_source.burst(1'b0, nl, 17 + {$random(seed)} % 24);
    repeat (6) @(posedge ref_clk);
    low_power <= 1'b0;
    rd_chk(`AEC_IDX_CTRL, x[23:16]);
    rd_chk(`AEC_IDX_UPPER, x[15:8]);
    rd_chk(`AEC_IDX_LOWER, x[7:0]);
    chk(n_irq, {30'h0, x[25:24]});
  endtask : run
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk(`AEC_IDX_CTRL, 8'h00);
    rd_chk(`AEC_IDX_UPPER, 8'h00);
    rd_chk(`AEC_IDX_LOWER, 8'h00);
    rd_chk(`AEC_IDX_GATING, 8'hff);
    apb(1'b0, 16'h0000, 8'h00);
    chk({31'h0, e}, 32'h1);
    for (i = 0; i < 6; i++) run($random(seed), {$random(seed)} % 20, {$random(seed)} % 20, $random(seed));
    run(6'h1f, 256, 0, 1'b0);
    run(6'h0f, 3, 257, 1'b0);
    run(6'h1f, 3, 256, 1'b1);
    run(6'h1f, 0, 256, 1'b0);
    apb(1'b1, `AEC_IDX_CTRL, 8'hdf);
    rd_chk(`AEC_IDX_CTRL, 8'h5f);
    apb(1'b1, `AEC_IDX_GATING, 8'h07);
    rd_chk(`AEC_IDX_GATING, 8'hf7);
    apb(1'b1, `AEC_IDX_CTRL, 8'h00);
    i_aec_event_source.burst(1'b0, 3, 20);
    repeat (6) @(posedge ref_clk);
    rd_chk(`AEC_IDX_CTRL, 8'h5f);
    apb(1'b1, `AEC_IDX_LOWER, 8'h55);
    rd_chk(`AEC_IDX_LOWER, 8'h00);
    give_verdict;
  end
endmodule : async_event_counter_test
bind aec_counter aec_counter_assertions i_aec_counter_assertions (.REF_CLK_I, .RESET_I, .PSEL_I, .PENABLE_I,
  .PADDR_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .LOW_POWER_I, .EVENT_IRQ_REQUEST_O);
